// file: verilog/pfw_pkg.sv
// Shared constants and types for the paged flash write path.
// Assumes a 200 MHz system clock and a serial link clocked by the bus master.
package pfw_pkg;

  // ==========================================================
  // Geometry
  localparam int BYTE_W = 8;
  localparam int OFS_W = 8;
  localparam int PAGE_BYTES = 256;
  localparam int TOP_LOCK_PAGES = 256;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int POR_TIME_NS = 10000;
  localparam logic [15:0] POR_CYC = 16'((POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ==========================================================
  // Opcodes
  localparam logic [7:0] OP_UNLOCK = 8'h06;
  localparam logic [7:0] OP_RDSTAT = 8'h05;
  localparam logic [7:0] OP_WRSTAT = 8'h01;
  localparam logic [7:0] OP_REWRITE = 8'h0A;
  localparam logic [7:0] OP_BURN = 8'h02;

  // ==========================================================
  // Frame bit positions, counted from zero at the first rising edge
  localparam logic [15:0] OPC_LAST_BIT = 16'h0007;
  localparam logic [15:0] STAT_LAST_BIT = 16'h000F;
  localparam logic [15:0] ADDR_LAST_BIT = 16'h001F;
  localparam logic [15:0] WRSTAT_MIN_BITS = 16'h0010;
  localparam logic [15:0] PAGE_MIN_BITS = 16'h0028;
  localparam logic [2:0] BYTE_LAST = 3'h7;
  localparam logic [2:0] PSIZE_MAX = 3'h7;
  localparam logic [1:0] PH_ADDR = 2'h0;
  localparam logic [1:0] PH_CAP = 2'h2;

  // ==========================================================
  // Synchroniser lanes
  localparam int SYNC_W = 4;
  localparam int SY_CS = 0;
  localparam int SY_TOG = 1;
  localparam int SY_LOCK = 2;
  localparam int SY_FRZ = 3;
  localparam logic [3:0] SYNC_RST = 4'hD;

  // ==========================================================
  // Types
  typedef struct packed {
    logic lock;
    logic [1:0] rsvd;
    logic [2:0] psize;
    logic latch;
    logic busy;
  } pfw_status_t;

  typedef struct packed {
    logic [7:0] opcode;
    logic [23:0] addr;
    logic [7:0] statData;
    logic [15:0] bits;
    logic tog;
  } pfw_frame_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_FILL = 3'h1,
    ST_ERASE = 3'h3,
    ST_PROG = 3'h2,
    ST_DONE = 3'h6
  } pfw_state_t;

endpackage

// file: verilog/pfw_flash_write_path.sv
// Serial command front end and page write sequencer of a paged flash.
// Assumes an external array with synchronous read (data one cycle after
// address), byte write strobe and page erase strobe; link clock from master.
`timescale 1ns/1ps

module pfw_flash_write_path
  import pfw_pkg::*;
#(
  parameter int PAGE_W = 12,
  parameter int ERASE_TIME_NS = 20000,
  parameter int PROG_TIME_NS = 5000
)
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic spiClk,
  input wire logic spiCsN,
  input wire logic spiMosi,
  output logic spiMiso,
  output logic spiMisoOe,
  input wire logic regionLockN,
  input wire logic areaFreezeN,
  output logic [PAGE_W+OFS_W-1:0] arrAddr,
  input wire logic [BYTE_W-1:0] arrRdData,
  output logic arrWrEn,
  output logic [BYTE_W-1:0] arrWrData,
  output logic arrEraseEn,
  output pfw_status_t status,
  output logic hardwareGuardMode
);

  localparam logic [15:0] ERASE_CYC = 16'((ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] PROG_CYC = 16'((PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [PAGE_W:0] PAGES_TOTAL = (PAGE_W+1)'(1 << PAGE_W);
  localparam logic [PAGE_W:0] TOP_PAGES = (PAGE_W+1)'(TOP_LOCK_PAGES);
  localparam logic [OFS_W-1:0] IDX_LAST = OFS_W'(PAGE_BYTES - 1);

  // ==========================================================
  // Link domain: frame capture
  logic [15:0] bitCnt_q;
  logic [15:0] bitCnt_d;
  logic [7:0] shift_q;
  logic [OFS_W-1:0] dataIdx_q;
  logic [OFS_W-1:0] dataIdx_d;
  pfw_frame_t frame_q;
  pfw_status_t statMeta_q;
  pfw_status_t statSync_q;
  logic [BYTE_W-1:0] pageBuf [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] mask_q;
  logic misoBit_q;
  logic misoOe_q;

  wire [7:0] rxByte = {shift_q[6:0], spiMosi};
  wire byteDone = bitCnt_q[2:0] == BYTE_LAST;
  wire opcDone = bitCnt_q == OPC_LAST_BIT;
  wire addrByte = byteDone && bitCnt_q > OPC_LAST_BIT && bitCnt_q <= ADDR_LAST_BIT;
  wire addrDone = bitCnt_q == ADDR_LAST_BIT;
  wire isPageCmd = frame_q.opcode == OP_REWRITE || frame_q.opcode == OP_BURN;
  // Buffer is frozen while a cycle runs, so a stray frame cannot corrupt it
  wire bufOpen = isPageCmd && !statSync_q.busy;
  wire dataByte = byteDone && bitCnt_q > ADDR_LAST_BIT && bufOpen;
  wire statDone = bitCnt_q == STAT_LAST_BIT && frame_q.opcode == OP_WRSTAT;
  wire rdStat = bitCnt_q > OPC_LAST_BIT && frame_q.opcode == OP_RDSTAT;
  wire [2:0] misoIdx = 3'(BYTE_LAST - bitCnt_q[2:0]);

  // Saturate so very long frames never alias to a short one
  assign bitCnt_d = (&bitCnt_q) ? bitCnt_q : 16'(bitCnt_q + 16'h0001);
  // buffer offset
  // Start offset is the low address byte; wraps inside the page
  assign dataIdx_d = addrDone ? rxByte : (dataByte ? OFS_W'(dataIdx_q + 1'b1) : dataIdx_q);

  // capture edge
  // Select high clears the frame logic; clock may be parked either way
  always_ff @(posedge spiClk or posedge spiCsN)
  begin
    if (spiCsN)
    begin
      bitCnt_q <= '0;
      shift_q <= '0;
      dataIdx_q <= '0;
    end
    else
    begin
      bitCnt_q <= bitCnt_d;
      shift_q <= rxByte;
      dataIdx_q <= dataIdx_d;
    end
  end

  // Summary survives deselect; the system side reads it after select rises
  always_ff @(posedge spiClk or negedge rstn)
  begin
    if (!rstn)
    begin
      frame_q <= '0;
    end
    // Edges while deselected, such as a mode change, must not count as a frame
    else if (!spiCsN)
    begin
      frame_q.bits <= bitCnt_d;
      if (bitCnt_q == '0)
      begin
        frame_q.tog <= ~frame_q.tog;
      end
      if (opcDone)
      begin
        frame_q.opcode <= rxByte;
      end
      if (addrByte)
      begin
        frame_q.addr <= {frame_q.addr[15:0], rxByte};
      end
      if (statDone)
      begin
        frame_q.statData <= rxByte;
      end
    end
  end

  always_ff @(posedge spiClk)
  begin
    if (dataByte)
    begin
      pageBuf[dataIdx_q] <= rxByte;
    end
  end

  always_ff @(posedge spiClk or negedge rstn)
  begin
    if (!rstn)
    begin
      mask_q <= '0;
    end
    else if (addrDone && bufOpen)
    begin
      mask_q <= '0;
    end
    else if (dataByte)
    begin
      mask_q[dataIdx_q] <= 1'b1;
    end
  end

  // Status bits change rarely; per-bit skew costs at most one stale poll
  always_ff @(posedge spiClk or negedge rstn)
  begin
    if (!rstn)
    begin
      statMeta_q <= '0;
      statSync_q <= '0;
    end
    else
    begin
      statMeta_q <= status;
      statSync_q <= statMeta_q;
    end
  end

  always_ff @(negedge spiClk or posedge spiCsN)
  begin
    if (spiCsN)
    begin
      misoBit_q <= 1'b0;
      misoOe_q <= 1'b0;
    end
    else
    begin
      misoOe_q <= rdStat;
      misoBit_q <= rdStat ? statSync_q[misoIdx] : 1'b0;
    end
  end

  assign spiMiso = misoBit_q;
  assign spiMisoOe = misoOe_q && !spiCsN;

  // ==========================================================
  // System domain: pin and frame synchronisers
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  logic [SYNC_W-1:0] sync3_q;
  logic [SYNC_W-1:0] pinStable_q;
  logic [SYNC_W-1:0] pinStable_d;
  logic togSeen_q;

  wire [SYNC_W-1:0] rawPins = {areaFreezeN, regionLockN, frame_q.tog, spiCsN};
  wire [SYNC_W-1:0] agree = sync2_q ~^ sync3_q;
  assign pinStable_d = (agree & sync2_q) | (~agree & pinStable_q);

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sync1_q <= SYNC_RST;
      sync2_q <= SYNC_RST;
      sync3_q <= SYNC_RST;
      pinStable_q <= SYNC_RST;
    end
    else
    begin
      sync1_q <= rawPins;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      pinStable_q <= pinStable_d;
    end
  end

  wire csRise = pinStable_d[SY_CS] && !pinStable_q[SY_CS];
  // A frame with no clock edges leaves the toggle alone and is ignored
  wire frameEnd = csRise && (pinStable_d[SY_TOG] != togSeen_q);

  // ==========================================================
  // System domain: power-on guard
  logic [15:0] porCnt_q;
  wire porDone = porCnt_q == POR_CYC;

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      porCnt_q <= '0;
      togSeen_q <= 1'b0;
    end
    else
    begin
      porCnt_q <= porDone ? porCnt_q : 16'(porCnt_q + 16'h0001);
      togSeen_q <= csRise ? pinStable_d[SY_TOG] : togSeen_q;
    end
  end

  // ==========================================================
  // System domain: command decode and protection
  pfw_state_t state_q;
  pfw_state_t state_d;
  logic [OFS_W-1:0] idx_q;
  logic [OFS_W-1:0] idx_d;
  logic [1:0] ph_q;
  logic [1:0] ph_d;
  logic [15:0] tmr_q;
  logic [15:0] tmr_d;
  logic [PAGE_W-1:0] page_q;
  logic isRewrite_q;
  logic latch_q;
  logic busy_q;
  logic [2:0] psize_q;
  logic lock_q;
  logic [BYTE_W-1:0] merged_q [PAGE_BYTES];

  wire [PAGE_W:0] reqPage = {1'b0, frame_q.addr[PAGE_W+OFS_W-1:OFS_W]};
  wire [PAGE_W:0] regionSize = PAGES_TOTAL >> (PSIZE_MAX - psize_q);
  wire inArea = psize_q != '0 && reqPage >= PAGES_TOTAL - regionSize;
  wire guarded = hardwareGuardMode && reqPage >= PAGES_TOTAL - TOP_PAGES;
  wire frozen = lock_q && !pinStable_q[SY_FRZ];
  wire bitsOk = frame_q.bits[2:0] == '0;
  wire cmdGate = frameEnd && porDone && !busy_q && bitsOk;
  wire isPageOp = frame_q.opcode == OP_REWRITE || frame_q.opcode == OP_BURN;
  wire startUnlock = cmdGate && frame_q.opcode == OP_UNLOCK;
  wire startStat = cmdGate && latch_q && frame_q.opcode == OP_WRSTAT
    && frame_q.bits >= WRSTAT_MIN_BITS;
  wire startPage = cmdGate && latch_q && isPageOp && frame_q.bits >= PAGE_MIN_BITS
    && !inArea && !guarded;
  wire cycleEnd = state_q == ST_DONE && tmr_q == '0;
  pfw_status_t newStat;
  assign newStat = pfw_status_t'(frame_q.statData);

  // ==========================================================
  // System domain: sequencer
  always_comb
  begin
    state_d = state_q;
    idx_d = idx_q;
    ph_d = ph_q;
    tmr_d = tmr_q;
    case (state_q)
      ST_IDLE:
      begin
        if (startPage)
        begin
          state_d = ST_FILL;
          idx_d = '0;
          ph_d = PH_ADDR;
        end
        else if (startStat)
        begin
          state_d = ST_DONE;
          tmr_d = '0;
        end
      end
      ST_FILL:
      begin
        if (ph_q == PH_CAP)
        begin
          ph_d = PH_ADDR;
          idx_d = OFS_W'(idx_q + 1'b1);
          if (idx_q == IDX_LAST)
          begin
            state_d = isRewrite_q ? ST_ERASE : ST_PROG;
            tmr_d = ERASE_CYC;
          end
        end
        else
        begin
          ph_d = 2'(ph_q + 1'b1);
        end
      end
      ST_ERASE:
      begin
        tmr_d = 16'(tmr_q - 16'h0001);
        if (tmr_q == '0)
        begin
          state_d = ST_PROG;
        end
      end
      ST_PROG:
      begin
        idx_d = OFS_W'(idx_q + 1'b1);
        if (idx_q == IDX_LAST)
        begin
          state_d = ST_DONE;
          tmr_d = PROG_CYC;
        end
      end
      ST_DONE:
      begin
        tmr_d = 16'(tmr_q - 16'h0001);
        if (tmr_q == '0)
        begin
          state_d = ST_IDLE;
        end
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q <= ST_IDLE;
      idx_q <= '0;
      ph_q <= PH_ADDR;
      tmr_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      idx_q <= idx_d;
      ph_q <= ph_d;
      tmr_q <= tmr_d;
    end
  end

  wire capture = state_q == ST_FILL && ph_q == PH_CAP;
  wire [BYTE_W-1:0] newByte = pageBuf[idx_q];
  wire [BYTE_W-1:0] mergeByte = !mask_q[idx_q] ? arrRdData
    : (isRewrite_q ? newByte : (newByte & arrRdData));

  always_ff @(posedge ref_clk)
  begin
    if (capture)
    begin
      merged_q[idx_q] <= mergeByte;
    end
  end

  wire enterErase = state_q == ST_FILL && state_d == ST_ERASE;
  wire progByte = state_q == ST_PROG;
  wire [PAGE_W+OFS_W-1:0] addrNext = enterErase ? {page_q, OFS_W'(0)} : {page_q, idx_q};

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      arrAddr <= '0;
      arrWrEn <= 1'b0;
      arrWrData <= '0;
      arrEraseEn <= 1'b0;
      page_q <= '0;
      isRewrite_q <= 1'b0;
    end
    else
    begin
      arrAddr <= addrNext;
      arrWrEn <= progByte;
      arrWrData <= merged_q[idx_q];
      arrEraseEn <= enterErase;
      page_q <= startPage ? reqPage[PAGE_W-1:0] : page_q;
      isRewrite_q <= startPage ? (frame_q.opcode == OP_REWRITE) : isRewrite_q;
    end
  end

  // ==========================================================
  // System domain: status register
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      latch_q <= 1'b0;
      busy_q <= 1'b0;
      psize_q <= '0;
      lock_q <= 1'b0;
    end
    else
    begin
      latch_q <= porDone && (startUnlock || (latch_q && !cycleEnd));
      busy_q <= state_d != ST_IDLE;
      if (startStat && !frozen)
      begin
        psize_q <= newStat.psize;
        lock_q <= newStat.lock;
      end
    end
  end

  assign status = '{lock: lock_q, rsvd: 2'h0, psize: psize_q, latch: latch_q, busy: busy_q};
  assign hardwareGuardMode = !pinStable_q[SY_LOCK];

endmodule // pfw_flash_write_path

// file: test/pfw_asserts.sv
// Checker for the paged flash write path, bound to its top module.
// Assumes the array strobes and status flops behave as handed over.
`timescale 1ns/1ps
module pfw_asserts
  import pfw_pkg::*;
#(
  parameter int PAGE_W = 12,
  parameter int ERASE_TIME_NS = 20000
)
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic spiCsN,
  input wire logic spiMisoOe,
  input wire logic regionLockN,
  input wire logic [PAGE_W+OFS_W-1:0] arrAddr,
  input wire logic arrWrEn,
  input wire logic arrEraseEn,
  input wire pfw_status_t status,
  input wire logic hardwareGuardMode
);
  // Capped so the delay range stays short for long erase times
  localparam int ERASE_MAX = (ERASE_TIME_NS / CLK_PERIOD_NS + 20 < 1000)
    ? ERASE_TIME_NS / CLK_PERIOD_NS + 20 : 1000;
  localparam int TOP_FIRST = 2 ** PAGE_W - TOP_LOCK_PAGES;
  logic [15:0] porQ;
  logic [8:0] wrRunQ;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  // ==========================================================
  // Helper counters
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      porQ <= 16'h0000;
      wrRunQ <= 9'h000;
    end
    else
    begin
      porQ <= (porQ == POR_CYC) ? porQ : porQ + 16'h0001;
      wrRunQ <= arrWrEn ? wrRunQ + 9'h001 : 9'h000;
    end
  end

  // ==========================================================
  // Properties
  oe_float_a: assert property (spiCsN |-> !spiMisoOe)
    else $error("serial output driven while deselected");
  guard_enter_a: assert property ($fell(regionLockN) |-> ##[1:6] hardwareGuardMode)
    else $error("guard mode not entered");
  guard_leave_a: assert property (regionLockN [*6] |-> !hardwareGuardMode)
    else $error("guard mode kept with lock pin high");
  top_guard_a: assert property (hardwareGuardMode && (arrWrEn || arrEraseEn)
    |-> arrAddr[PAGE_W+7:8] < TOP_FIRST)
    else $error("top page modified in guard mode");
  por_latch_a: assert property (porQ < POR_CYC |-> !status.latch)
    else $error("latch set during power-on guard");
  busy_start_a: assert property ($rose(status.busy) |-> spiCsN)
    else $error("cycle started while selected");
  erase_once_a: assert property (arrEraseEn |-> status.busy ##1 !arrEraseEn)
    else $error("erase strobe not a single busy pulse");
  erase_prog_a: assert property (arrEraseEn |-> ##[1:ERASE_MAX] arrWrEn)
    else $error("program did not follow erase");
  wr_busy_a: assert property (arrWrEn |-> status.busy)
    else $error("array written while not busy");
  wr_run_a: assert property ($fell(arrWrEn) |-> wrRunQ == 9'h100)
    else $error("program burst not one whole page");
  latch_clear_a: assert property ($fell(status.busy) |-> !status.latch)
    else $error("latch kept after completion");
endmodule // pfw_asserts

bind pfw_flash_write_path pfw_asserts #(.PAGE_W(PAGE_W), .ERASE_TIME_NS(ERASE_TIME_NS)) chk (
  .ref_clk(ref_clk), .rstn(rstn), .spiCsN(spiCsN), .spiMisoOe(spiMisoOe),
  .regionLockN(regionLockN), .arrAddr(arrAddr), .arrWrEn(arrWrEn),
  .arrEraseEn(arrEraseEn), .status(status), .hardwareGuardMode(hardwareGuardMode));

// file: test/pfw_spi_master.sv
// Behavioural bus master driving the serial link of the flash.
// Assumes the bench calls its tasks; link clock period 80 ns.
`timescale 1ns/1ps
module pfw_spi_master
(
  output logic spiClk,
  output logic spiCsN,
  output logic spiMosi,
  input wire logic spiMiso
);
  logic cpol;
  initial
  begin
    cpol = 1'b0;
    spiClk = 1'b0;
    spiCsN = 1'b1;
    spiMosi = 1'b0;
  end

  // ==========================================================
  // Tasks
  // idle clock level
  task setMode(input logic m);
    cpol = m;
    spiClk = m;
    // Let the idle level settle before the next select
    #80;
  endtask

  task xfer(input logic [319:0] tx, input int n, output logic [319:0] rx);
    rx = '0;
    spiCsN = 1'b0;
    for (int i = n - 1; i >= 0; i--)
    begin
      #40 spiClk = 1'b0;
      spiMosi = tx[i];
      #40 spiClk = 1'b1;
      rx = {rx[318:0], spiMiso};
    end
    #40 spiClk = cpol;
    #40 spiCsN = 1'b1;
    // Released data line must not keep its value
    spiMosi = ~spiMosi;
    #100;
  endtask
endmodule // pfw_spi_master

// file: test/test_paged_flash_spi_write_path.sv
// Self-checking bench for the paged flash write path.
// Assumes the bus-master model and a behavioural byte array here.
`timescale 1ns/1ps
module test_paged_flash_spi_write_path
  import pfw_pkg::*;
;
  localparam int PW = 9;
  localparam int AW = PW + OFS_W;
  logic ref_clk = 1'b0;
  logic rstn, regionLockN, areaFreezeN, spiClk, spiCsN, spiMosi, dutMiso, spiMisoOe;
  logic arrWrEn, arrEraseEn, hardwareGuardMode, misoLine;
  logic [AW-1:0] arrAddr;
  logic [7:0] arrRdData, arrWrData;
  logic [7:0] mem [0:(1<<AW)-1];
  logic [319:0] rx;
  pfw_status_t status;
  int n_mismatch, compares;
  int cyc = 0;

  always #2.5 ref_clk = ~ref_clk;
  // undriven line shows the opposite level
  assign misoLine = spiMisoOe ? dutMiso : ~dutMiso;

  pfw_flash_write_path #(.PAGE_W(PW), .ERASE_TIME_NS(50), .PROG_TIME_NS(25)) DUT (
    .ref_clk(ref_clk), .rstn(rstn), .spiClk(spiClk), .spiCsN(spiCsN),
    .spiMosi(spiMosi), .spiMiso(dutMiso), .spiMisoOe(spiMisoOe),
    .regionLockN(regionLockN), .areaFreezeN(areaFreezeN), .arrAddr(arrAddr),
    .arrRdData(arrRdData), .arrWrEn(arrWrEn), .arrWrData(arrWrData),
    .arrEraseEn(arrEraseEn), .status(status), .hardwareGuardMode(hardwareGuardMode));

  pfw_spi_master MST (.spiClk(spiClk), .spiCsN(spiCsN), .spiMosi(spiMosi), .spiMiso(misoLine));

  // ==========================================================
  // Array model
  always @(posedge ref_clk)
  begin
    arrRdData <= mem[arrAddr];
    if (arrWrEn)
      mem[arrAddr] <= arrWrData;
    if (arrEraseEn)
      for (int i = 0; i < 256; i++)
        mem[{arrAddr[AW-1:8], 8'(i)}] <= 8'hFF;
  end

  // ==========================================================
  // Tasks
  function automatic logic [7:0] pat(input int a);
    return 8'(a) ^ 8'h5A;
  endfunction

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task run(input logic [319:0] tx, input int n);
    int k;
    k = 0;
    MST.xfer(tx, n, rx);
    while (status.busy !== 1'b0 && k < 4000)
    begin
      tick(1);
      k++;
    end
    chk(status.busy, 1'b0);
  endtask

  task stop_test();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Ceiling well above the roughly 12k cycles the tests need
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      n_mismatch++;
      stop_test();
    end
  end

  // ==========================================================
  // Tests
  initial
  begin
    rstn = 1'b0;
    regionLockN = 1'b1;
    areaFreezeN = 1'b1;
    n_mismatch = 0;
    compares = 0;
    for (int i = 0; i < (1 << AW); i++)
      mem[i] = pat(i);
    tick(2);
    chk(status, 8'h00);
    tick(2);
    // reset released once supply is good
    rstn = 1'b1;
    MST.xfer({312'h0, OP_UNLOCK}, 8, rx);
    tick(20);
    chk(status.latch, 1'b0);
    $display("test power-on done");
    tick(2000);
    run({280'h0, OP_REWRITE, 24'h0003FE, 8'hA1}, 40);
    chk(mem['h3FE], pat('h3FE));
    $display("test no-unlock done");
    MST.setMode(1'b1);
    run({312'h0, OP_UNLOCK}, 8);
    chk(status.latch, 1'b1);
    run({264'h0, OP_REWRITE, 24'h0003FE, 24'hA1B2C3}, 56);
    chk(mem['h3FE], 8'hA1);
    chk(mem['h3FF], 8'hB2);
    chk(mem['h300], 8'hC3);
    chk(mem['h301], pat('h301));
    chk(status.latch, 1'b0);
    MST.setMode(1'b0);
    $display("test rewrite done");
    run({312'h0, OP_UNLOCK}, 8);
    run({280'h0, OP_BURN, 24'h000310, 8'h0F}, 40);
    chk(mem['h310], pat('h310) & 8'h0F);
    $display("test burn done");
    run({312'h0, OP_UNLOCK}, 8);
    run({279'h0, OP_REWRITE, 24'h000320, 8'h55, 1'b1}, 41);
    chk(mem['h320], pat('h320));
    chk(status.latch, 1'b1);
    $display("test bit-count done");
    regionLockN = 1'b0;
    tick(8);
    chk(hardwareGuardMode, 1'b1);
    run({280'h0, OP_REWRITE, 24'h01F000, 8'h77}, 40);
    chk(mem['h1F000], pat('h1F000));
    regionLockN = 1'b1;
    tick(8);
    chk(hardwareGuardMode, 1'b0);
    run({280'h0, OP_REWRITE, 24'h01F000, 8'h77}, 40);
    chk(mem['h1F000], 8'h77);
    $display("test top lock done");
    run({312'h0, OP_UNLOCK}, 8);
    run({304'h0, OP_WRSTAT, 8'h84}, 16);
    run({304'h0, OP_RDSTAT, 8'h00}, 16);
    chk(rx[7:0], 8'h84);
    chk(spiMisoOe, 1'b0);
    areaFreezeN = 1'b0;
    tick(8);
    run({312'h0, OP_UNLOCK}, 8);
    run({304'h0, OP_WRSTAT, 8'h00}, 16);
    chk({status.lock, status.psize}, 4'h9);
    // Size 1 guards the top eight pages
    run({312'h0, OP_UNLOCK}, 8);
    run({280'h0, OP_REWRITE, 24'h01FF00, 8'h33}, 40);
    chk(mem['h1FF00], pat('h1FF00));
    chk(status.latch, 1'b1);
    $display("test status done");
    stop_test();
  end
endmodule // test_paged_flash_spi_write_path
